//--- shared/dac_cmd_map.svh
`ifndef DAC_CMD_MAP_SVH
`define DAC_CMD_MAP_SVH

// Register-map (I2C/SPI) addresses
`define ADDR_FAST_CODE_BASE 8'h40
`define ADDR_BROADCAST 8'h50

// PMBus command codes and pages
`define CMD_PAGE 8'h00
`define CMD_OPERATION 8'h01
`define CMD_COMM_FAULT 8'h78
`define CMD_BROADCAST 8'hF1
`define PAGE_GLOBAL 8'hFF
`define PAGE_LAST_CHANNEL 8'h03

// Operation codes
`define OP_OFF 8'h00
`define OP_ON 8'h80
`define OP_MARGIN_HIGH 8'hA4
`define OP_MARGIN_LOW 8'h94

// Field positions
`define COMM_FAULT_BIT 9
`define BROADCAST_LSB 4

// Reset values
`define RST_PAGE 16'h0300
`define RST_BROADCAST 16'h0000
`define RST_OPERATION 16'h0000
`define RST_FAST_CODE 16'h0000

`endif

//--- shared/dac_cmd_pkg.sv
package dac_cmd_pkg;
  typedef enum logic [1:0] {
    OUT_OFF,
    OUT_ON,
    OUT_MARGIN_HIGH,
    OUT_MARGIN_LOW
  } out_mode_t;
endpackage

//--- core/chan_word_store.sv
`timescale 1ns/1ps
// ----------------------------------------
// Small per-channel word store, registered read
// ----------------------------------------
module chan_word_store #(
  parameter int WORDS = 4,
  parameter int AW = 2
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [WORDS-1:0] wr_en,
  input wire logic [15:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [15:0] rd_data,
  output logic [WORDS*16-1:0] all_words
);
  logic [15:0] mem_ff [WORDS];
  logic [15:0] nxt_mem [WORDS];
  logic [15:0] rd_data_ff;
  logic [15:0] nxt_rd_data;

  always_comb begin
    for (int i = 0; i < WORDS; i++) begin
      nxt_mem[i] = wr_en[i] ? wr_data : mem_ff[i];
    end
    nxt_rd_data = mem_ff[rd_addr];
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_ff[i] <= 16'h0000;
      end
      rd_data_ff <= 16'h0000;
    end else begin
      for (int i = 0; i < WORDS; i++) begin
        mem_ff[i] <= nxt_mem[i];
      end
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;

  always_comb begin
    for (int i = 0; i < WORDS; i++) begin
      all_words[i*16 +: 16] = mem_ff[i];
    end
  end
endmodule

//--- core/dac_command_regs.sv
`timescale 1ns/1ps
`include "dac_cmd_map.svh"
// ----------------------------------------
// Summary of operation
// ----------------------------------------
// Summary of operation
// (RULE1) Per-channel 8-bit current code held in bits 15-8, low byte ignored.
// (RULE2) Fast current code only on register map, never reachable over PMBus.
// (RULE3) Broadcast code is bits 15-4, left aligned; 10-bit ignores two lowest.
// (RULE4) Broadcast write updates only channels with participation enabled.
// (RULE5) PMBus broadcast code sits at command F1h on page FFh.
// (RULE6) Page selector in upper byte at command 00h on any page.
// (RULE7) Operation command at 01h; pages 00h-03h pick channels 0-3.
// (RULE8) Operation 00h off, 80h on, A4h margin high.
// (RULE9) Operation 94h selects margin low.
// (RULE10) Fault flag bit 9 set on clock count, read-first, address, data errors.
// (RULE11) Fault flag stays set until host writes one; zero leaves it.
// (RULE12) Fault register at command 78h regardless of page.
// (RULE13) Host sets page before any paged command.
// (RULE14) Unknown operation byte rejected, output unchanged, fault flag set.
module dac_command_regs #(
  parameter int CHANNELS = 4,
  parameter int RESOLUTION = 12
) (
  input wire logic mclk,
  input wire logic nrst,
  // Register-map (I2C/SPI) access
  input wire logic map_wr,
  input wire logic map_rd,
  input wire logic [7:0] map_addr,
  input wire logic [15:0] map_wdata,
  output logic [15:0] map_rdata,
  // PMBus access, frame already decoded by the serial front end
  input wire logic pm_wr,
  input wire logic pm_rd,
  input wire logic [7:0] pm_cmd,
  input wire logic [15:0] pm_wdata,
  input wire logic pm_clock_count_err,
  input wire logic pm_read_before_write,
  output logic [15:0] pm_rdata,
  // Per-channel participation bits from the function setup registers
  input wire logic [CHANNELS-1:0] broadcast_participation_enable,
  output logic [CHANNELS*8-1:0] channel_fast_current_code,
  output logic [CHANNELS*RESOLUTION-1:0] channel_code,
  output logic [CHANNELS-1:0] channel_code_load,
  output logic [CHANNELS*2-1:0] channel_out_mode,
  output logic comm_fault_flag
);
  localparam int AW = $clog2(CHANNELS);

  logic [15:0] broadcast_ff, nxt_broadcast;
  logic [7:0] page_ff, nxt_page;
  logic fault_ff, nxt_fault;
  dac_cmd_pkg::out_mode_t mode_ff [CHANNELS];
  dac_cmd_pkg::out_mode_t nxt_mode [CHANNELS];
  logic [7:0] op_ff [CHANNELS];
  logic [7:0] nxt_op [CHANNELS];
  logic [CHANNELS*RESOLUTION-1:0] code_ff, nxt_code;
  logic [CHANNELS-1:0] load_ff, nxt_load;
  logic [15:0] map_rdata_ff, nxt_map_rdata;
  logic [15:0] pm_rdata_ff, nxt_pm_rdata;

  logic [CHANNELS-1:0] fast_wr;
  logic [15:0] fast_rd;
  logic [CHANNELS*16-1:0] fast_words;
  logic [AW-1:0] fast_rd_idx;
  logic fast_hit;

  function automatic logic is_channel_page(input logic [7:0] pg);
    return pg <= `PAGE_LAST_CHANNEL;
  endfunction

  function automatic logic valid_op(input logic [7:0] op);
    return op == `OP_OFF || op == `OP_ON || op == `OP_MARGIN_HIGH || op == `OP_MARGIN_LOW;
  endfunction

  // ----------------------------------------
  // Fast current code store
  // ----------------------------------------
  // (RULE2) Map decode only
  assign fast_hit = map_addr >= `ADDR_FAST_CODE_BASE &&
                    map_addr < `ADDR_FAST_CODE_BASE + 8'(CHANNELS);
  assign fast_rd_idx = AW'(map_addr - `ADDR_FAST_CODE_BASE);

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      fast_wr[i] = map_wr && fast_hit && fast_rd_idx == AW'(i);
    end
  end

  // (RULE1) Low byte dropped on store
  chan_word_store #(.WORDS(CHANNELS), .AW(AW)) u_fast (
    .mclk(mclk),
    .nrst(nrst),
    .wr_en(fast_wr),
    .wr_data({map_wdata[15:8], 8'h00}),
    .rd_addr(fast_rd_idx),
    .rd_data(fast_rd),
    .all_words(fast_words)
  );

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      channel_fast_current_code[i*8 +: 8] = fast_words[i*16+8 +: 8];
    end
  end

  // ----------------------------------------
  // Register and command state
  // ----------------------------------------
  always_comb begin
    logic bc_wr;
    logic bc_map;
    logic pm_known;
    bc_wr = 1'b0;
    bc_map = 1'b0;
    pm_known = 1'b0;
    nxt_broadcast = broadcast_ff;
    nxt_page = page_ff;
    nxt_fault = fault_ff;
    nxt_code = code_ff;
    nxt_load = '0;
    nxt_map_rdata = map_rdata_ff;
    nxt_pm_rdata = pm_rdata_ff;
    for (int i = 0; i < CHANNELS; i++) begin
      nxt_mode[i] = mode_ff[i];
      nxt_op[i] = op_ff[i];
    end

    // (RULE5) Broadcast on page FFh
    bc_map = map_wr && map_addr == `ADDR_BROADCAST;
    bc_wr = bc_map || (pm_wr && pm_cmd == `CMD_BROADCAST && page_ff == `PAGE_GLOBAL);
    if (bc_wr) begin
      // (RULE3) Keep bits 15-4
      // Source picked by the map hit, so a map write elsewhere cannot steal a PMBus broadcast
      nxt_broadcast = {(bc_map ? map_wdata[15:4] : pm_wdata[15:4]), 4'h0};
      // (RULE4) Participating channels only
      for (int i = 0; i < CHANNELS; i++) begin
        if (broadcast_participation_enable[i]) begin
          nxt_code[i*RESOLUTION +: RESOLUTION] = nxt_broadcast[15 -: RESOLUTION];
          nxt_load[i] = 1'b1;
        end
      end
    end

    if (map_rd) begin
      if (fast_hit) begin
        nxt_map_rdata = 16'h0000;
      end else if (map_addr == `ADDR_BROADCAST) begin
        nxt_map_rdata = broadcast_ff;
      end else begin
        nxt_map_rdata = 16'h0000;
      end
    end

    if (pm_wr || pm_rd) begin
      // (RULE6) Page selector on any page
      if (pm_cmd == `CMD_PAGE) begin
        pm_known = 1'b1;
        if (pm_wr) begin
          nxt_page = pm_wdata[15:8];
        end
        nxt_pm_rdata = {page_ff, 8'h00};
      end else if (pm_cmd == `CMD_COMM_FAULT) begin
        // (RULE12) Page independent
        pm_known = 1'b1;
        nxt_pm_rdata = 16'(fault_ff) << `COMM_FAULT_BIT;
        // (RULE11) Write one clears
        if (pm_wr && pm_wdata[`COMM_FAULT_BIT]) begin
          nxt_fault = 1'b0;
        end
      end else if (pm_cmd == `CMD_OPERATION && is_channel_page(page_ff)) begin
        // (RULE7) Page picks channel
        pm_known = 1'b1;
        nxt_pm_rdata = {op_ff[AW'(page_ff)], 8'h00};
        if (pm_wr) begin
          if (valid_op(pm_wdata[15:8])) begin
            nxt_op[AW'(page_ff)] = pm_wdata[15:8];
            // (RULE8) Off, on, margin high
            if (pm_wdata[15:8] == `OP_OFF) begin
              nxt_mode[AW'(page_ff)] = dac_cmd_pkg::OUT_OFF;
            end else if (pm_wdata[15:8] == `OP_ON) begin
              nxt_mode[AW'(page_ff)] = dac_cmd_pkg::OUT_ON;
            end else if (pm_wdata[15:8] == `OP_MARGIN_HIGH) begin
              nxt_mode[AW'(page_ff)] = dac_cmd_pkg::OUT_MARGIN_HIGH;
            end else begin
              // (RULE9) Margin low
              nxt_mode[AW'(page_ff)] = dac_cmd_pkg::OUT_MARGIN_LOW;
            end
          end else begin
            // (RULE14) Reject unknown op
            nxt_fault = 1'b1;
          end
        end
      end else if (pm_cmd == `CMD_BROADCAST && page_ff == `PAGE_GLOBAL) begin
        pm_known = 1'b1;
        nxt_pm_rdata = broadcast_ff;
      end
      // (RULE10) Bad address sets fault
      if (!pm_known) begin
        nxt_fault = 1'b1;
        nxt_pm_rdata = 16'h0000;
      end
    end

    // (RULE10) Framing errors; set wins over clear
    if (pm_clock_count_err || pm_read_before_write) begin
      nxt_fault = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      broadcast_ff <= `RST_BROADCAST;
      page_ff <= 8'h03;
      fault_ff <= 1'b0;
      code_ff <= '0;
      load_ff <= '0;
      map_rdata_ff <= 16'h0000;
      pm_rdata_ff <= 16'h0000;
      for (int i = 0; i < CHANNELS; i++) begin
        mode_ff[i] <= dac_cmd_pkg::OUT_OFF;
        op_ff[i] <= 8'h00;
      end
    end else begin
      broadcast_ff <= nxt_broadcast;
      page_ff <= nxt_page;
      fault_ff <= nxt_fault;
      code_ff <= nxt_code;
      load_ff <= nxt_load;
      map_rdata_ff <= nxt_map_rdata;
      pm_rdata_ff <= nxt_pm_rdata;
      for (int i = 0; i < CHANNELS; i++) begin
        mode_ff[i] <= nxt_mode[i];
        op_ff[i] <= nxt_op[i];
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Fast code reads come out of the store one cycle after the request, same as others
  logic fast_rd_pend_ff, nxt_fast_rd_pend;
  assign nxt_fast_rd_pend = map_rd && fast_hit;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fast_rd_pend_ff <= 1'b0;
    end else begin
      fast_rd_pend_ff <= nxt_fast_rd_pend;
    end
  end

  assign map_rdata = fast_rd_pend_ff ? fast_rd : map_rdata_ff;
  assign pm_rdata = pm_rdata_ff;
  assign comm_fault_flag = fault_ff;
  assign channel_code = code_ff;
  assign channel_code_load = load_ff;

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      channel_out_mode[i*2 +: 2] = mode_ff[i];
    end
  end
endmodule

//--- sim/host_model.sv
`timescale 1ns/1ps
// --------------------------
// Host side, frames decoded
// --------------------------
module host_model (
  input wire logic mclk,
  output logic map_wr,
  output logic map_rd,
  output logic [7:0] map_addr,
  output logic [15:0] map_wdata,
  input wire logic [15:0] map_rdata,
  output logic pm_wr,
  output logic pm_rd,
  output logic [7:0] pm_cmd,
  output logic [15:0] pm_wdata,
  output logic pm_clock_count_err,
  output logic pm_read_before_write,
  input wire logic [15:0] pm_rdata
);
  initial begin
    {map_wr, map_rd, pm_wr, pm_rd, pm_clock_count_err, pm_read_before_write} = 6'h00;
    {map_addr, pm_cmd} = 16'h0000;
    {map_wdata, pm_wdata} = 32'h0000_0000;
  end
  // Released data is inverted so a stale word is never mistaken for a live one
  task automatic map_acc(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    @(negedge mclk);
    map_wr = wr;
    map_rd = !wr;
    map_addr = a;
    map_wdata = d;
    @(negedge mclk);
    {map_wr, map_rd} = 2'h0;
    map_wdata = ~d;
    q = map_rdata;
  endtask
  task automatic pm_acc(input logic wr, input logic [7:0] c, input logic [15:0] d, output logic [15:0] q);
    @(negedge mclk);
    pm_wr = wr;
    pm_rd = !wr;
    pm_cmd = c;
    pm_wdata = d;
    @(negedge mclk);
    {pm_wr, pm_rd} = 2'h0;
    pm_wdata = ~d;
    q = pm_rdata;
  endtask
  task automatic pm_err(input logic sel);
    @(negedge mclk);
    pm_clock_count_err = !sel;
    pm_read_before_write = sel;
    @(negedge mclk);
    {pm_clock_count_err, pm_read_before_write} = 2'h0;
  endtask
endmodule

//--- sim/dac_cmd_monitor.sv
`timescale 1ns/1ps
// --------------------------
// Port checker
// --------------------------
module dac_cmd_monitor #(
  parameter int CHANNELS = 4,
  parameter int RESOLUTION = 12
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic map_wr,
  input wire logic [7:0] map_addr,
  input wire logic [15:0] map_wdata,
  input wire logic pm_wr,
  input wire logic [7:0] pm_cmd,
  input wire logic [15:0] pm_wdata,
  input wire logic pm_clock_count_err,
  input wire logic pm_read_before_write,
  input wire logic [CHANNELS-1:0] broadcast_participation_enable,
  input wire logic [CHANNELS*8-1:0] channel_fast_current_code,
  input wire logic [CHANNELS*RESOLUTION-1:0] channel_code,
  input wire logic [CHANNELS-1:0] channel_code_load,
  input wire logic [CHANNELS*2-1:0] channel_out_mode,
  input wire logic comm_fault_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire logic clr = pm_wr && pm_cmd == 8'h78 && pm_wdata[9];
  wire logic bc = map_wr && map_addr == 8'h50 && !(pm_wr && pm_cmd == 8'hF1);
  wire logic bad_op = pm_wr && pm_cmd == 8'h01 && !(pm_wdata[15:8] inside {8'h00, 8'h80, 8'hA4, 8'h94});
  count_fault_a: assert property (pm_clock_count_err |=> comm_fault_flag) else $error("fault not set");
  fault_sticky_a: assert property (comm_fault_flag && !clr |=> comm_fault_flag) else $error("fault lost");
  fault_clear_a: assert property (clr && !pm_clock_count_err && !pm_read_before_write |=> !comm_fault_flag)
    else $error("fault not cleared");
  fast_code_a: assert property (map_wr && map_addr == 8'h40 |=>
    channel_fast_current_code[7:0] == $past(map_wdata[15:8])) else $error("fast code wrong");
  bcast_mask_a: assert property (bc |=> channel_code_load == $past(broadcast_participation_enable))
    else $error("broadcast mask wrong");
  bcast_code_a: assert property (bc && broadcast_participation_enable[0] |=>
    channel_code[RESOLUTION-1:0] == $past(map_wdata[15:16-RESOLUTION])) else $error("broadcast code wrong");
  mode_hold_a: assert property (!pm_wr |=> $stable(channel_out_mode)) else $error("mode moved");
  op_reject_a: assert property (bad_op |=> $stable(channel_out_mode) && comm_fault_flag)
    else $error("bad op taken");
endmodule

bind dac_command_regs dac_cmd_monitor #(.CHANNELS(CHANNELS), .RESOLUTION(RESOLUTION)) u_mon (
  .mclk(mclk), .nrst(nrst), .map_wr(map_wr), .map_addr(map_addr), .map_wdata(map_wdata),
  .pm_wr(pm_wr), .pm_cmd(pm_cmd), .pm_wdata(pm_wdata), .pm_clock_count_err(pm_clock_count_err),
  .pm_read_before_write(pm_read_before_write), .broadcast_participation_enable(broadcast_participation_enable),
  .channel_fast_current_code(channel_fast_current_code), .channel_code(channel_code),
  .channel_code_load(channel_code_load), .channel_out_mode(channel_out_mode), .comm_fault_flag(comm_fault_flag)
);

//--- sim/dac_command_regs_tb.sv
`timescale 1ns/1ps
module dac_command_regs_tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic map_wr, map_rd, pm_wr, pm_rd, ccerr, rbw, fault;
  logic [7:0] map_addr, pm_cmd, mode;
  logic [15:0] map_wdata, map_rdata, pm_wdata, pm_rdata, q;
  logic [3:0] bpe = 4'h0;
  logic [3:0] load;
  logic [31:0] fast;
  logic [47:0] code;
  logic [7:0] ops [4] = '{8'h00, 8'h80, 8'hA4, 8'h94};
  int miscompares = 0;
  int num_checks = 0;
  always #5 mclk = ~mclk;
  host_model u_host (.mclk(mclk), .map_wr(map_wr), .map_rd(map_rd), .map_addr(map_addr),
    .map_wdata(map_wdata), .map_rdata(map_rdata), .pm_wr(pm_wr), .pm_rd(pm_rd), .pm_cmd(pm_cmd),
    .pm_wdata(pm_wdata), .pm_clock_count_err(ccerr), .pm_read_before_write(rbw), .pm_rdata(pm_rdata));
  dac_command_regs u_dut (.mclk(mclk), .nrst(nrst), .map_wr(map_wr), .map_rd(map_rd), .map_addr(map_addr),
    .map_wdata(map_wdata), .map_rdata(map_rdata), .pm_wr(pm_wr), .pm_rd(pm_rd), .pm_cmd(pm_cmd),
    .pm_wdata(pm_wdata), .pm_clock_count_err(ccerr), .pm_read_before_write(rbw), .pm_rdata(pm_rdata),
    .broadcast_participation_enable(bpe), .channel_fast_current_code(fast), .channel_code(code),
    .channel_code_load(load), .channel_out_mode(mode), .comm_fault_flag(fault));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic pw(input logic [7:0] c, input logic [15:0] d);
    u_host.pm_acc(1'b1, c, d, q);
  endtask
  task automatic ckf(input logic e);
    chk("fault", {15'h0, e}, {15'h0, fault});
  endtask
  task automatic summarize();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge mclk);
    nrst = 1'b1;
    u_host.pm_acc(1'b0, 8'h00, 16'h0000, q);
    chk("page", 16'h0300, q);
    ckf(1'b0);
    for (int i = 0; i < 4; i++) begin
      u_host.map_acc(1'b1, 8'h40 + i[7:0], {8'hC1 + i[7:0], 8'h5A}, q);
    end
    for (int i = 0; i < 4; i++) begin
      u_host.map_acc(1'b0, 8'h40 + i[7:0], 16'h0000, q);
      chk("fast read", {8'hC1 + i[7:0], 8'h00}, q);
      chk("fast out", {8'h00, 8'hC1 + i[7:0]}, {8'h00, fast[i*8 +: 8]});
    end
    pw(8'h40, 16'h1100);
    chk("fast via pmbus", 16'h00C1, {8'h00, fast[7:0]});
    ckf(1'b1);
    pw(8'h78, 16'h0000);
    ckf(1'b1);
    pw(8'h78, 16'h0200);
    ckf(1'b0);
    for (int s = 0; s < 2; s++) begin
      u_host.pm_err(s[0]);
      ckf(1'b1);
      pw(8'h78, 16'h0200);
    end
    bpe = 4'b0101;
    u_host.map_acc(1'b1, 8'h50, 16'hABCD, q);
    chk("bcast ch0", 16'h0ABC, {4'h0, code[11:0]});
    chk("bcast ch1", 16'h0000, {4'h0, code[23:12]});
    chk("bcast ch2", 16'h0ABC, {4'h0, code[35:24]});
    chk("bcast load", 16'h0005, {12'h000, load});
    u_host.map_acc(1'b0, 8'h50, 16'h0000, q);
    chk("bcast read", 16'hABC0, q);
    bpe = 4'b1010;
    pw(8'h00, 16'hFF00);
    pw(8'hF1, 16'h1234);
    chk("pm bcast ch1", 16'h0123, {4'h0, code[23:12]});
    chk("pm bcast ch0", 16'h0ABC, {4'h0, code[11:0]});
    chk("pm bcast load", 16'h000A, {12'h000, load});
    pw(8'h00, 16'h0000);
    pw(8'hF1, 16'h5670);
    ckf(1'b1);
    u_host.pm_acc(1'b0, 8'h78, 16'h0000, q);
    chk("fault reg", 16'h0200, q & 16'h0200);
    pw(8'h78, 16'h0200);
    for (int c = 0; c < 4; c++) begin
      pw(8'h00, {c[7:0], 8'h00});
      for (int k = 0; k < 4; k++) begin
        pw(8'h01, {ops[k], 8'h00});
        chk("op mode", k[15:0], {14'h0, mode[c*2 +: 2]});
      end
      pw(8'h01, 16'h5500);
      chk("op bad", 16'h0003, {14'h0, mode[c*2 +: 2]});
      ckf(1'b1);
      u_host.pm_acc(1'b0, 8'h01, 16'h0000, q);
      chk("op kept", 16'h9400, q);
      pw(8'h78, 16'h0200);
    end
    chk("modes", 16'h00FF, {8'h00, mode});
    pw(8'h00, 16'h0400);
    pw(8'h01, 16'h8000);
    ckf(1'b1);
    chk("page four", 16'h00FF, {8'h00, mode});
    summarize();
  end
endmodule
